// ---- core/rtcb_core.sv ----
// real-time clock: calibrated seconds tick, day counter, alarm, flags, backup charger control
//
// How it works
// - clock_disable bit stops counting; reset runs
// - time base divided to 1 Hz tick
// - seconds counter wraps after 86399 to zero
// - rollover increments 15-bit day counter
// - tick sets flag; line only when unmasked
// - alarm flag when time and day match
// - alarm wakes system when off; interrupts whether on or off
// - backup reset clears all clock contents
// - timer-reset flag set after backup reset
// - signed calibration word adjusts tick divider
// - correction -16..+15 counts per period
// - calibration touches only the tick divider
// - mode 00 off, 01 main, 11 always
// - mode 01 suspends on backup cell
// - cell connects at power-on or charger enable while system on
// - charger enable and 3-bit voltage select
// - off state charges at low current
// - undervoltage halts charging
// - charger enable cleared by host write or backup reset
// - flags latched until host writes one
// - masks reset set; unmask raises pending line
//
// Register access over APB and the register addresses were chosen for this implementation.

`include "rtcb_defines.svh"

module rtcb_core
    import rtcb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_clk_in,
    input wire logic system_on,
    input wire logic on_backup_cell,
    input wire logic main_undervoltage,
    output logic irq,
    output logic wake_request,
    output logic charger_on,
    output logic low_charge_current,
    output logic [2:0] charge_voltage_sel,
    output logic backup_cell_connect
);

    rtcb_state_t st_r;
    rtcb_state_t st_nxt;

    logic slow_rise;
    logic on_rise;
    logic cal_active;
    logic [15:0] div_last;
    logic tick;
    logic tod_wrap;
    logic match;
    logic alarm_evt;
    logic acc;
    logic wr;
    logic rd;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic mapped;
    logic [31:0] rdata;

    always_comb
    begin
        st_nxt = st_r;
        // three-stage pin samplers; a level counts once stages two and three agree
        st_nxt.slow_s = {st_r.slow_s[1:0], slow_clk_in};
        st_nxt.on_s = {st_r.on_s[1:0], system_on};
        st_nxt.bkp_s = {st_r.bkp_s[1:0], on_backup_cell};
        st_nxt.uv_s = {st_r.uv_s[1:0], main_undervoltage};
        if (st_r.slow_s[1] == st_r.slow_s[2])
        begin
            st_nxt.slow_lvl = st_r.slow_s[2];
        end
        if (st_r.on_s[1] == st_r.on_s[2])
        begin
            st_nxt.on_lvl = st_r.on_s[2];
        end
        if (st_r.bkp_s[1] == st_r.bkp_s[2])
        begin
            st_nxt.bkp_lvl = st_r.bkp_s[2];
        end
        if (st_r.uv_s[1] == st_r.uv_s[2])
        begin
            st_nxt.uv_lvl = st_r.uv_s[2];
        end
        slow_rise = st_nxt.slow_lvl & ~st_r.slow_lvl;
        on_rise = st_nxt.on_lvl & ~st_r.on_lvl;

        // reserved mode 10 is treated as off rather than guessed at
        unique case (st_r.cal_mode)
            RTCB_CAL_MAIN_ONLY: cal_active = ~st_r.bkp_lvl;
            RTCB_CAL_ALWAYS: cal_active = 1'b1;
            RTCB_CAL_OFF,
            RTCB_CAL_RESERVED: cal_active = 1'b0;
        endcase

        // the slow clock output never passes through here, only the tick count
        div_last = `RTCB_DIV_LAST;
        if (cal_active)
        begin
            div_last = `RTCB_DIV_LAST + {{11{st_r.cal[4]}}, st_r.cal};
        end

        // >= keeps a shortened period from running past its end after a new word
        tick = slow_rise & ~st_r.clk_dis & (st_r.div >= div_last);
        tod_wrap = tick & (st_r.seconds_of_day_counter == `RTCB_TOD_LAST);
        if (slow_rise && !st_r.clk_dis)
        begin
            st_nxt.div = tick ? 16'h0000 : st_r.div + 16'h0001;
        end
        if (tick)
        begin
            st_nxt.seconds_of_day_counter = tod_wrap ? 17'h00000 : st_r.seconds_of_day_counter + 17'h00001;
        end
        if (tod_wrap)
        begin
            st_nxt.day = st_r.day + 15'h0001;
        end

        acc = psel & penable & st_r.pready;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        // decoded apart from the direction so a refused write is flagged like a read
        mapped = (paddr[1:0] == 2'h0) && (paddr <= `RTCB_ADDR_STATUS);
        flag_clr = 3'h0;
        if (wr)
        begin
            unique case (paddr)
                `RTCB_ADDR_CTRL:
                begin
                    st_nxt.clk_dis = pwdata[`RTCB_CTRL_DIS_BIT];
                    st_nxt.cal_mode = rtcb_cal_mode_t'(pwdata[`RTCB_CTRL_MODE_LSB +: 2]);
                    st_nxt.chg_en = pwdata[`RTCB_CTRL_CHGEN_BIT];
                    st_nxt.vsel = pwdata[`RTCB_CTRL_VSEL_LSB +: 3];
                end
                `RTCB_ADDR_CAL: st_nxt.cal = pwdata[4:0];
                `RTCB_ADDR_TOD: st_nxt.seconds_of_day_counter = pwdata[16:0];
                `RTCB_ADDR_DAY: st_nxt.day = pwdata[14:0];
                `RTCB_ADDR_ALARM_TIME_REGISTER: st_nxt.alarm_time_register = pwdata[16:0];
                `RTCB_ADDR_ALARM_DAY_REGISTER: st_nxt.alarm_day_register = pwdata[14:0];
                `RTCB_ADDR_INT_STAT: flag_clr = pwdata[2:0];
                `RTCB_ADDR_INT_MASK: st_nxt.mask = pwdata[2:0];
                `RTCB_ADDR_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end

        // edge of the compare so a held match raises the flag once
        match = (st_nxt.seconds_of_day_counter == st_nxt.alarm_time_register) && (st_nxt.day == st_nxt.alarm_day_register);
        st_nxt.match_prev = match;
        alarm_evt = match & ~st_r.match_prev;

        flag_set = 3'h0;
        flag_set[`RTCB_INT_TICK_BIT] = tick;
        flag_set[`RTCB_INT_ALARM_BIT] = alarm_evt;
        // a new event in the clearing cycle survives the clear
        st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;
        st_nxt.irq = |(st_nxt.flags & ~st_nxt.mask);
        st_nxt.wake = alarm_evt & ~st_r.on_lvl;

        st_nxt.chg_on = st_nxt.chg_en & ~st_r.uv_lvl;
        st_nxt.chg_low = st_nxt.chg_en & ~st_r.on_lvl;
        // once connected the cell stays on; only the backup reset drops it
        if (on_rise || (st_nxt.chg_en && st_r.on_lvl))
        begin
            st_nxt.cell_conn = 1'b1;
        end

        rdata = 32'h0000_0000;
        if (!pwrite)
        begin
            unique case (paddr)
                `RTCB_ADDR_CTRL:
                begin
                    rdata[`RTCB_CTRL_DIS_BIT] = st_r.clk_dis;
                    rdata[`RTCB_CTRL_MODE_LSB +: 2] = st_r.cal_mode;
                    rdata[`RTCB_CTRL_CHGEN_BIT] = st_r.chg_en;
                    rdata[`RTCB_CTRL_VSEL_LSB +: 3] = st_r.vsel;
                end
                `RTCB_ADDR_CAL: rdata[4:0] = st_r.cal;
                `RTCB_ADDR_TOD: rdata[16:0] = st_r.seconds_of_day_counter;
                `RTCB_ADDR_DAY: rdata[14:0] = st_r.day;
                `RTCB_ADDR_ALARM_TIME_REGISTER: rdata[16:0] = st_r.alarm_time_register;
                `RTCB_ADDR_ALARM_DAY_REGISTER: rdata[14:0] = st_r.alarm_day_register;
                `RTCB_ADDR_INT_STAT: rdata[2:0] = st_r.flags;
                `RTCB_ADDR_INT_MASK: rdata[2:0] = st_r.mask;
                `RTCB_ADDR_STATUS:
                begin
                    rdata[`RTCB_STAT_ON_BIT] = st_r.on_lvl;
                    rdata[`RTCB_STAT_BKP_BIT] = st_r.bkp_lvl;
                    rdata[`RTCB_STAT_UV_BIT] = st_r.uv_lvl;
                    rdata[`RTCB_STAT_CHG_BIT] = st_r.chg_on;
                    rdata[`RTCB_STAT_LOW_BIT] = st_r.chg_low;
                    rdata[`RTCB_STAT_CONN_BIT] = st_r.cell_conn;
                    rdata[`RTCB_STAT_CALACT_BIT] = cal_active;
                end
                default: mapped = 1'b0;
            endcase
        end

        // one wait state: pready rises in the second access cycle
        st_nxt.pready = psel & penable & ~st_r.pready;
        st_nxt.pslverr = psel & penable & ~st_r.pready & ~mapped;
        st_nxt.prdata = st_r.prdata;
        if (psel && penable && !st_r.pready)
        begin
            st_nxt.prdata = rdata;
        end
        if (rd || wr)
        begin
            st_nxt.prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.flags <= `RTCB_FLAGS_RESET;
            st_r.mask <= `RTCB_MASK_RESET;
            st_r.match_prev <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq = st_r.irq;
    assign wake_request = st_r.wake;
    assign charger_on = st_r.chg_on;
    assign low_charge_current = st_r.chg_low;
    assign charge_voltage_sel = st_r.vsel;
    assign backup_cell_connect = st_r.cell_conn;

endmodule // rtcb_core

// ---- core/rtcb_defines.svh ----
// register map, field positions, reset values and counts of the clock block
`ifndef RTCB_DEFINES_SVH
`define RTCB_DEFINES_SVH

`define RTCB_ADDR_CTRL 8'h00
`define RTCB_ADDR_CAL 8'h04
`define RTCB_ADDR_TOD 8'h08
`define RTCB_ADDR_DAY 8'h0C
`define RTCB_ADDR_ALARM_TIME_REGISTER 8'h10
`define RTCB_ADDR_ALARM_DAY_REGISTER 8'h14
`define RTCB_ADDR_INT_STAT 8'h18
`define RTCB_ADDR_INT_MASK 8'h1C
`define RTCB_ADDR_STATUS 8'h20

`define RTCB_CTRL_DIS_BIT 0
`define RTCB_CTRL_MODE_LSB 1
`define RTCB_CTRL_CHGEN_BIT 3
`define RTCB_CTRL_VSEL_LSB 4

`define RTCB_INT_TICK_BIT 0
`define RTCB_INT_ALARM_BIT 1
`define RTCB_INT_TRST_BIT 2

`define RTCB_STAT_ON_BIT 0
`define RTCB_STAT_BKP_BIT 1
`define RTCB_STAT_UV_BIT 2
`define RTCB_STAT_CHG_BIT 3
`define RTCB_STAT_LOW_BIT 4
`define RTCB_STAT_CONN_BIT 5
`define RTCB_STAT_CALACT_BIT 6

`define RTCB_FLAGS_RESET 3'h4
`define RTCB_MASK_RESET 3'h7
`define RTCB_MODE_RESET 2'h0

`define RTCB_DIV_LAST 16'h7FFF
`define RTCB_TOD_LAST 17'h1517F

`endif

// ---- core/rtcb_pkg.sv ----
// types of the clock block
package rtcb_pkg;

    typedef enum logic [1:0] {
        RTCB_CAL_OFF = 2'h0,
        RTCB_CAL_MAIN_ONLY = 2'h1,
        RTCB_CAL_RESERVED = 2'h2,
        RTCB_CAL_ALWAYS = 2'h3
    } rtcb_cal_mode_t;

    typedef struct packed {
        logic [2:0] slow_s;
        logic [2:0] on_s;
        logic [2:0] bkp_s;
        logic [2:0] uv_s;
        logic slow_lvl;
        logic on_lvl;
        logic bkp_lvl;
        logic uv_lvl;
        logic [15:0] div;
        logic [16:0] seconds_of_day_counter;
        logic [14:0] day;
        logic [16:0] alarm_time_register;
        logic [14:0] alarm_day_register;
        logic clk_dis;
        rtcb_cal_mode_t cal_mode;
        logic chg_en;
        logic [2:0] vsel;
        logic [4:0] cal;
        logic [2:0] flags;
        logic [2:0] mask;
        logic match_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic wake;
        logic chg_on;
        logic chg_low;
        logic cell_conn;
    } rtcb_state_t;

endpackage

// ---- verif/rtcb_core_assertions.sv ----
// port checks of the clock block, bound into its top module
module rtcb_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic system_on,
    input wire logic main_undervoltage,
    input wire logic irq,
    input wire logic wake_request,
    input wire logic charger_on,
    input wire logic low_charge_current,
    input wire logic backup_cell_connect
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pins pass a 3-flop sampler, so levels are judged only after they stood a while
    a_irq_after_reset: assert property ($rose(presetn) |-> !irq)
        else $error("irq high right after reset");
    a_wake_when_on: assert property (system_on [*6] |-> !wake_request)
        else $error("wake request while system on");
    a_wake_single: assert property (wake_request |=> !wake_request)
        else $error("wake request longer than one cycle");
    a_uv_halts: assert property (main_undervoltage [*6] |-> !charger_on)
        else $error("charging under undervoltage");
    a_low_when_on: assert property (system_on [*6] |-> !low_charge_current)
        else $error("low current while system on");
    a_low_when_off: assert property ((!system_on) [*6] ##0 charger_on
        |-> low_charge_current)
        else $error("high current while system off");
    a_conn_sticky: assert property (backup_cell_connect |=> backup_cell_connect)
        else $error("cell disconnected");
    a_conn_power_on: assert property ($rose(system_on) ##0 system_on [*8]
        |-> backup_cell_connect)
        else $error("cell not connected at power on");
    cover property (wake_request);
    cover property (irq ##1 !irq);
    cover property (charger_on && low_charge_current);
endmodule // rtcb_chk

bind rtcb_core rtcb_chk rtcb_chk_i (.*);

// ---- verif/rtcb_timebase.sv ----
// slow time base source standing in for the crystal oscillator
module rtcb_timebase (
    input wire logic pclk,
    input wire logic run,
    output logic slow_clk_in,
    output int edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph = 2'h0;
    // two pclk per level: fast enough for a short run, slow enough for the sampler
    always @(posedge pclk)
    begin
        if (run)
            ph <= ph + 2'h1;
        if (run && ph == 2'h1)
            edges <= edges + 1;
    end
    initial edges = 0;
    assign slow_clk_in = ph[1];
endmodule // rtcb_timebase

// ---- verif/test_rtc_time_day_alarm_calibration.sv ----
// self-checking bench of the clock block
`include "rtcb_defines.svh"
module test_rtc_time_day_alarm_calibration;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, wake_request, charger_on, low_charge_current;
    logic backup_cell_connect, slow_clk_in;
    logic system_on = 0, on_backup_cell = 0, main_undervoltage = 0;
    logic [2:0] charge_voltage_sel;
    int edges, error_cnt = 0, check_count = 0, wake_cnt = 0, cyc = 0, n;
    always #2 pclk = ~pclk;
    rtcb_core rtcb_core_i (.*);
    rtcb_timebase rtcb_timebase_i (.pclk(pclk), .run(run), .slow_clk_in(slow_clk_in),
        .edges(edges));
    task complete_run();
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (wake_request === 1'b1)
            wake_cnt++;
        if (cyc == 140000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // holds the whole request until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
        input logic xe);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (!w)
            cmp(prdata, x);
        cmp({pready, pslverr}, {1'b1, xe});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b0);
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp(irq, 32'h0);
        rd(`RTCB_ADDR_INT_STAT, 32'h4);
        rd(`RTCB_ADDR_INT_MASK, 32'h7);
        rd(`RTCB_ADDR_CTRL, 32'h0);
        apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h24, 32'hFF, 32'h0, 1'b1);
        wr(`RTCB_ADDR_INT_MASK, 32'h3);
        repeat (3) @(posedge pclk);
        cmp(irq, 32'h1);
        wr(`RTCB_ADDR_INT_STAT, 32'h4);
        repeat (2) @(posedge pclk);
        cmp(irq, 32'h0);
        rd(`RTCB_ADDR_INT_STAT, 32'h0);
        wr(`RTCB_ADDR_TOD, 32'h64);
        wr(`RTCB_ADDR_DAY, 32'h7);
        wr(`RTCB_ADDR_ALARM_TIME_REGISTER, 32'h64);
        wr(`RTCB_ADDR_ALARM_DAY_REGISTER, 32'h7);
        rd(`RTCB_ADDR_INT_STAT, 32'h2);
        cmp(wake_cnt, 32'h1);
        cmp(backup_cell_connect, 32'h0);
        system_on <= 1'b1;
        repeat (8) @(posedge pclk);
        cmp(backup_cell_connect, 32'h1);
        wr(`RTCB_ADDR_INT_STAT, 32'h2);
        wr(`RTCB_ADDR_ALARM_DAY_REGISTER, 32'h8);
        wr(`RTCB_ADDR_ALARM_DAY_REGISTER, 32'h7);
        rd(`RTCB_ADDR_INT_STAT, 32'h2);
        cmp(wake_cnt, 32'h1);
        wr(`RTCB_ADDR_INT_STAT, 32'h2);
        wr(`RTCB_ADDR_CTRL, 32'h59);
        repeat (2) @(posedge pclk);
        cmp({charger_on, low_charge_current, charge_voltage_sel}, 32'h15);
        system_on <= 1'b0;
        repeat (8) @(posedge pclk);
        cmp(low_charge_current, 32'h1);
        main_undervoltage <= 1'b1;
        repeat (8) @(posedge pclk);
        cmp(charger_on, 32'h0);
        rd(`RTCB_ADDR_STATUS, 32'h34);
        rd(`RTCB_ADDR_CTRL, 32'h59);
        main_undervoltage <= 1'b0;
        // backup reset in mid-run: contents, charger enable and cell link all drop
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`RTCB_ADDR_CTRL, 32'h0);
        rd(`RTCB_ADDR_ALARM_TIME_REGISTER, 32'h0);
        rd(`RTCB_ADDR_INT_STAT, 32'h4);
        wr(`RTCB_ADDR_INT_STAT, 32'h4);
        wr(`RTCB_ADDR_ALARM_DAY_REGISTER, 32'h7);
        wr(`RTCB_ADDR_CTRL, 32'h5A);
        on_backup_cell <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(`RTCB_ADDR_STATUS, 32'h1A);
        on_backup_cell <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(`RTCB_ADDR_STATUS, 32'h58);
        wr(`RTCB_ADDR_TOD, 32'h1517F);
        wr(`RTCB_ADDR_DAY, 32'h7FFF);
        wr(`RTCB_ADDR_CAL, 32'h0F);
        // refreshed to the most negative word; the reserved mode code is never written
        wr(`RTCB_ADDR_CAL, 32'h10);
        rd(`RTCB_ADDR_CAL, 32'h10);
        wr(`RTCB_ADDR_INT_MASK, 32'h6);
        wr(`RTCB_ADDR_CTRL, 32'h5E);
        run <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 135000)
        begin
            @(posedge pclk);
            n++;
        end
        cmp(edges inside {32752, 32753}, 32'h1);
        rd(`RTCB_ADDR_TOD, 32'h0);
        rd(`RTCB_ADDR_DAY, 32'h0);
        rd(`RTCB_ADDR_INT_STAT, 32'h1);
        complete_run();
    end
endmodule // test_rtc_time_day_alarm_calibration
